// File: fctir_cfg.svh
/*
 * register offsets, field positions, reset values and timing constants of the timer.
 * assumes word addressing on a 32-bit avalon bus: byte address is four times the index.
 */
`ifndef FCTIR_CFG_SVH
`define FCTIR_CFG_SVH

// register indices, byte address = 4 * index
`define FCTIR_IDX_CNT 8'hc4
`define FCTIR_IDX_SCR1 8'hc6
`define FCTIR_IDX_MODE 8'hc0
`define FCTIR_IDX_IRQEN 8'hca
`define FCTIR_IDX_SCR2 8'hcb
`define FCTIR_IDX_FLG1 8'hcc
`define FCTIR_IDX_FLG2 8'hcd
`define FCTIR_IDX_CH0 8'hce
`define FCTIR_IDX_CH1 8'hd0
`define FCTIR_IDX_CH2 8'hd2
`define FCTIR_IDX_CH3 8'hd4

// field positions
`define FCTIR_SCR1_FFC_BIT 4
`define FCTIR_SCR2_OVIE_BIT 7
`define FCTIR_SCR2_CRE_BIT 3
`define FCTIR_FLG2_OVF_BIT 7

// reset values
`define FCTIR_RST_BYTE 8'h00
`define FCTIR_RST_WORD 16'h0000

// timing
`define FCTIR_CLK_MHZ 125
`define FCTIR_PRE_W 7

`endif

// File: fctir_pkg.sv
/*
 * types of the four-channel timer.
 * assumes nothing beyond a systemverilog compiler.
 */
package fctir_pkg;
    typedef enum logic [2:0] {
        FCTIR_BUS_IDLE = 3'b001,
        FCTIR_BUS_ACK = 3'b010,
        FCTIR_BUS_HOLD = 3'b100
    } fctir_bus_state_t;
endpackage

// File: fctir_prescaler.sv
/*
 * clock prescaler producing a one-cycle timer tick at bus clock / 2**select.
 * assumes select comes from a register in the same clock domain.
 */
`timescale 1ns/1ps
`include "fctir_cfg.svh"

module fctir_prescaler #(
    parameter int PRE_W = `FCTIR_PRE_W
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // control
    input wire logic [2:0] div_sel,
    // tick out
    output logic tick
);
    logic [PRE_W-1:0] cnt_q, cnt_d;
    logic [2:0] sel_q, sel_d;
    logic [PRE_W-1:0] mask;

    always_comb begin
        mask = PRE_W'((8'h01 << sel_q) - 8'h01);
        cnt_d = (cnt_q + PRE_W'(1)) & mask;
        sel_d = sel_q;
        // new divisor loaded only when every stage is back at zero
        if (cnt_d == '0) begin
            sel_d = div_sel;
        end
        tick = (cnt_q == mask);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            sel_q <= 3'h0;
        end else begin
            cnt_q <= cnt_d;
            sel_q <= sel_d;
        end
    end
endmodule

// File: fctir_timer.sv
/*
 * four-channel 16-bit capture/compare timer with avalon-mm register slave.
 * assumes capture pins are asynchronous and are synchronised here.
 */
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "fctir_cfg.svh"

module fctir_timer #(
    parameter int NCH = 4
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // avalon-mm slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [1:0] avs_response,
    // capture inputs, edge selection
    input wire logic [NCH-1:0] capture_pin,
    input wire logic [NCH-1:0] capture_rise_en,
    input wire logic [NCH-1:0] capture_fall_en,
    // compare match pulses
    output logic [NCH-1:0] compare_match,
    // interrupts
    output logic [NCH-1:0] channel_irq,
    output logic overflow_irq,
    output logic irq
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    fctir_pkg::fctir_bus_state_t st_q, st_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] resp_q, resp_d;
    logic [15:0] cnt_q, cnt_d;
    logic [NCH-1:0] irq_en_q, irq_en_d;
    logic [NCH-1:0] mode_q, mode_d;
    logic fast_clr_q, fast_clr_d;
    logic ovf_ie_q, ovf_ie_d;
    logic cre_q, cre_d;
    logic [2:0] div_sel_q, div_sel_d;
    logic [NCH-1:0] flags_q, flags_d;
    logic ovf_q, ovf_d;
    logic [15:0] chan_q [NCH], chan_d [NCH];
    logic [NCH-1:0] sync1_q, sync2_q, prev_q;
    logic [NCH-1:0] match_q, match_d;
    logic [NCH-1:0] chirq_q, chirq_d;
    logic ovirq_q, ovirq_d, irq_q, irq_d;
    logic wait_q, wait_d;
    logic tick;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] lane_merge(input logic [7:0] old, input logic [7:0] nw, input logic en);
        lane_merge = en ? nw : old;
    endfunction

    function automatic int chan_of(input logic [7:0] idx);
        chan_of = -1;
        if (idx == `FCTIR_IDX_CH0) chan_of = 0;
        if (idx == `FCTIR_IDX_CH1) chan_of = 1;
        if (idx == `FCTIR_IDX_CH2) chan_of = 2;
        if (idx == `FCTIR_IDX_CH3) chan_of = 3;
    endfunction

    // ----------------------------------------------------------------
    // prescaler
    // ----------------------------------------------------------------
    fctir_prescaler #(
        .PRE_W(`FCTIR_PRE_W)
    ) u_pre (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .div_sel(div_sel_q),
        .tick(tick)
    );

    // ----------------------------------------------------------------
    // capture synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q <= '0;
        end else begin
            sync1_q <= capture_pin;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic acc;
        logic wr;
        logic rd;
        int ch;
        logic [NCH-1:0] evt;
        logic [NCH-1:0] clr;
        logic wrap;
        logic cmp_rst;
        logic [7:0] b0;
        logic [7:0] b1;
        acc = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        ch = -1;
        evt = '0;
        clr = '0;
        wrap = 1'b0;
        cmp_rst = 1'b0;
        b0 = 8'h00;
        b1 = 8'h00;
        st_d = st_q;
        rdata_d = rdata_q;
        resp_d = resp_q;
        cnt_d = cnt_q;
        irq_en_d = irq_en_q;
        mode_d = mode_q;
        fast_clr_d = fast_clr_q;
        ovf_ie_d = ovf_ie_q;
        cre_d = cre_q;
        div_sel_d = div_sel_q;
        flags_d = flags_q;
        ovf_d = ovf_q;
        chan_d = chan_q;
        match_d = '0;

        case (st_q)
            fctir_pkg::FCTIR_BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    acc = 1'b1;
                    st_d = fctir_pkg::FCTIR_BUS_ACK;
                end
            end
            fctir_pkg::FCTIR_BUS_ACK: begin
                st_d = fctir_pkg::FCTIR_BUS_HOLD;
            end
            fctir_pkg::FCTIR_BUS_HOLD: begin
                st_d = fctir_pkg::FCTIR_BUS_IDLE;
            end
            default: begin
                st_d = fctir_pkg::FCTIR_BUS_IDLE;
            end
        endcase
        // waitrequest registered so the port comes straight from a flop
        wait_d = (st_d != fctir_pkg::FCTIR_BUS_ACK);
        wr = acc && avs_write;
        rd = acc && avs_read;
        ch = chan_of(avs_address);

        // counter, compare and capture
        for (int i = 0; i < NCH; i++) begin
            if (mode_q[i]) begin
                // compare mode
                if (tick && cnt_q == chan_q[i]) begin
                    evt[i] = 1'b1;
                    match_d[i] = 1'b1;
                end
            end else if ((capture_rise_en[i] && sync2_q[i] && !prev_q[i]) ||
                         (capture_fall_en[i] && !sync2_q[i] && prev_q[i])) begin
                // capture mode latches counter
                evt[i] = 1'b1;
                chan_d[i] = cnt_q;
            end
        end
        if (tick) begin
            cmp_rst = cre_q && mode_q[3] && evt[3];
            if (cmp_rst) begin
                cnt_d = 16'h0000;
            end else begin
                cnt_d = cnt_q + 16'h0001;
                wrap = (cnt_q == 16'hffff);
            end
        end

        // register access
        b0 = avs_writedata[7:0];
        b1 = avs_writedata[15:8];
        if (rd) begin
            rdata_d = 32'h0000_0000;
            resp_d = 2'b00;
            case (avs_address)
                `FCTIR_IDX_CNT: rdata_d[15:0] = cnt_q;
                `FCTIR_IDX_SCR1: rdata_d[`FCTIR_SCR1_FFC_BIT] = fast_clr_q;
                `FCTIR_IDX_MODE: rdata_d[NCH-1:0] = mode_q;
                `FCTIR_IDX_IRQEN: rdata_d[NCH-1:0] = irq_en_q;
                `FCTIR_IDX_SCR2: rdata_d[7:0] = {ovf_ie_q, 3'h0, cre_q, div_sel_q};
                `FCTIR_IDX_FLG1: rdata_d[NCH-1:0] = flags_q;
                `FCTIR_IDX_FLG2: rdata_d[`FCTIR_FLG2_OVF_BIT] = ovf_q;
                default: begin
                    if (ch >= 0) begin
                        rdata_d[15:0] = chan_q[ch];
                    end else begin
                        resp_d = 2'b10;
                    end
                end
            endcase
        end
        if (wr) begin
            resp_d = 2'b00;
            case (avs_address)
                `FCTIR_IDX_CNT: begin
                end
                `FCTIR_IDX_SCR1: begin
                    if (avs_byteenable[0]) fast_clr_d = b0[`FCTIR_SCR1_FFC_BIT];
                end
                `FCTIR_IDX_MODE: begin
                    if (avs_byteenable[0]) mode_d = b0[NCH-1:0];
                end
                `FCTIR_IDX_IRQEN: begin
                    if (avs_byteenable[0]) irq_en_d = b0[NCH-1:0];
                end
                `FCTIR_IDX_SCR2: begin
                    if (avs_byteenable[0]) begin
                        ovf_ie_d = b0[`FCTIR_SCR2_OVIE_BIT];
                        cre_d = b0[`FCTIR_SCR2_CRE_BIT];
                        div_sel_d = b0[2:0];
                    end
                end
                `FCTIR_IDX_FLG1: begin
                    if (avs_byteenable[0]) clr = b0[NCH-1:0];
                end
                `FCTIR_IDX_FLG2: begin
                    if (avs_byteenable[0] && b0[`FCTIR_FLG2_OVF_BIT]) ovf_d = 1'b0;
                end
                default: begin
                    if (ch >= 0) begin
                        // capture-mode writes are dropped
                        if (mode_q[ch]) begin
                            chan_d[ch] = {lane_merge(chan_q[ch][15:8], b1, avs_byteenable[1]),
                                          lane_merge(chan_q[ch][7:0], b0, avs_byteenable[0])};
                        end
                    end else begin
                        resp_d = 2'b10;
                    end
                end
            endcase
        end
        // fast clear side effects
        if (fast_clr_q && ch >= 0 && ((rd && !mode_q[ch]) || (wr && mode_q[ch]))) begin
            clr[ch] = 1'b1;
        end
        if (fast_clr_q && (rd || wr) && avs_address == `FCTIR_IDX_CNT) begin
            ovf_d = 1'b0;
        end
        // hardware set wins over clear
        flags_d = (flags_q & ~clr) | evt;
        if (wrap) begin
            ovf_d = 1'b1;
        end

        // interrupt levels
        chirq_d = flags_d & irq_en_d;
        ovirq_d = ovf_d && ovf_ie_d;
        irq_d = (|chirq_d) || ovirq_d;
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= fctir_pkg::FCTIR_BUS_IDLE;
            rdata_q <= 32'h0000_0000;
            resp_q <= 2'b00;
            cnt_q <= `FCTIR_RST_WORD;
            irq_en_q <= '0;
            mode_q <= '0;
            fast_clr_q <= 1'b0;
            ovf_ie_q <= 1'b0;
            cre_q <= 1'b0;
            div_sel_q <= 3'h0;
            flags_q <= '0;
            ovf_q <= 1'b0;
            for (int i = 0; i < NCH; i++) begin
                chan_q[i] <= `FCTIR_RST_WORD;
            end
            match_q <= '0;
            chirq_q <= '0;
            ovirq_q <= 1'b0;
            irq_q <= 1'b0;
            wait_q <= 1'b1;
        end else begin
            st_q <= st_d;
            rdata_q <= rdata_d;
            resp_q <= resp_d;
            cnt_q <= cnt_d;
            irq_en_q <= irq_en_d;
            mode_q <= mode_d;
            fast_clr_q <= fast_clr_d;
            ovf_ie_q <= ovf_ie_d;
            cre_q <= cre_d;
            div_sel_q <= div_sel_d;
            flags_q <= flags_d;
            ovf_q <= ovf_d;
            chan_q <= chan_d;
            match_q <= match_d;
            chirq_q <= chirq_d;
            ovirq_q <= ovirq_d;
            irq_q <= irq_d;
            wait_q <= wait_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    always_comb begin
        avs_readdata = rdata_q;
        avs_response = resp_q;
        // low only in the ack state, one cycle after the request is taken
        avs_waitrequest = wait_q;
        compare_match = match_q;
        channel_irq = chirq_q;
        overflow_irq = ovirq_q;
        irq = irq_q;
    end
endmodule

// File: fctir_timer_monitor.sv
/*
 * concurrent checks on the ports of the four-channel timer.
 * assumes it is bound to fctir_timer and sees its ports only.
 */
`timescale 1ns/1ps
`include "fctir_cfg.svh"

module fctir_timer_monitor #(
    parameter int NCH = 4
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // bus
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [1:0] avs_response,
    // interrupts
    input wire logic [NCH-1:0] channel_irq,
    input wire logic overflow_irq,
    input wire logic irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    logic ack;
    assign ack = !avs_waitrequest;

    a_wait_hold:
        assert property (ack |=> avs_waitrequest [*2]) else $error("answer longer than one cycle");
    a_answer_bound:
        assert property ((avs_read || avs_write) && avs_waitrequest |-> ##[0:3] ack) else $error("no answer");
    a_irq_sum:
        assert property (irq == (|channel_irq || overflow_irq)) else $error("irq not the sum");
    a_unmapped_err:
        assert property (ack && avs_address < 8'hc0 |-> avs_response == 2'b10) else $error("no error response");
    a_unmapped_zero:
        assert property (ack && avs_read && avs_address < 8'hc0 |-> avs_readdata == 32'h0) else $error("data on hole");
    a_mapped_ok:
        assert property (ack && avs_address == `FCTIR_IDX_FLG1 |-> avs_response == 2'b00) else $error("bad response");
    a_flag_upper:
        assert property (ack && avs_read && avs_address == `FCTIR_IDX_FLG1 |-> avs_readdata[31:4] == 28'h0)
            else $error("flag spare bits set");
    a_ovf_upper:
        assert property (ack && avs_read && avs_address == `FCTIR_IDX_FLG2 |-> avs_readdata[6:0] == 7'h0)
            else $error("overflow spare bits set");
    a_irqen_upper:
        assert property (ack && avs_read && avs_address == `FCTIR_IDX_IRQEN |-> avs_readdata[31:4] == 28'h0)
            else $error("enable spare bits set");
endmodule

// File: tb_fctir_timer.sv
/*
 * self-checking bench of the four-channel timer.
 * assumes the design files and fctir_cfg.svh are compiled first.
 */
`timescale 1ns/1ps
`include "fctir_cfg.svh"
`define TB_CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("unexpected at %0t: got %h expected %h", $time, a, b); end end

module tb_fctir_timer;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [1:0] avs_response;
    logic [3:0] capture_pin = 4'h0;
    logic [3:0] capture_rise_en = 4'h0;
    logic [3:0] capture_fall_en = 4'h0;
    logic [3:0] channel_irq;
    logic [3:0] compare_match;
    logic overflow_irq;
    logic irq;
    int n_mismatch = 0;
    int checks = 0;
    logic [17:0] exp_q[$];
    logic [31:0] rnd = 32'h760a6e46;
    logic [15:0] v[3];

    fctir_timer i_dut (.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
        .capture_pin(capture_pin), .capture_rise_en(capture_rise_en), .capture_fall_en(capture_fall_en),
        .compare_match(compare_match), .channel_irq(channel_irq), .overflow_irq(overflow_irq), .irq(irq));

    initial begin
        forever #4 core_clk = ~core_clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic stop_test();
        $display("mismatches %0d, checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------
    // bus master
    // ----------------------------------------
    task automatic acc(input logic wr, input logic [7:0] a, input logic [15:0] d);
        int n = 0;
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {16'h0, d};
        avs_byteenable <= 4'h3;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (n >= 20) begin
            n_mismatch++;
            stop_test();
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [1:0] r, input logic [15:0] e);
        exp_q.push_back({r, e});
        acc(1'b0, a, 16'h0);
    endtask

    // read results are matched against the oldest note
    always @(posedge core_clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            if (exp_q.size() == 0) begin
                n_mismatch++;
            end else begin
                `TB_CHK({avs_response, avs_readdata[15:0]}, exp_q.pop_front())
            end
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        int k;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rd(`FCTIR_IDX_IRQEN, 2'b00, 16'h0000);
        rd(`FCTIR_IDX_SCR2, 2'b00, 16'h0000);
        rd(8'h10, 2'b10, 16'h0000);
        // compare loop of 0x41 counts (0 to 0x40), random compare points below 0x40
        acc(1'b1, `FCTIR_IDX_MODE, 16'h000f);
        for (int i = 0; i < 3; i++) begin
            rnd = lfsr(rnd);
            v[i] = {10'h0, rnd[5:0] | 6'h01};
            acc(1'b1, `FCTIR_IDX_CH0 + 8'(2 * i), v[i]);
        end
        acc(1'b1, `FCTIR_IDX_CH3, 16'h0040);
        acc(1'b1, `FCTIR_IDX_SCR2, 16'h0008);
        acc(1'b1, `FCTIR_IDX_IRQEN, 16'h0005);
        repeat (150) @(posedge core_clk);
        rd(`FCTIR_IDX_FLG1, 2'b00, 16'h000f);
        `TB_CHK(channel_irq, 4'h5)
        `TB_CHK(overflow_irq, 1'b0)
        rd(`FCTIR_IDX_CH0, 2'b00, v[0]);
        acc(1'b1, `FCTIR_IDX_FLG1, 16'h0000);
        rd(`FCTIR_IDX_FLG1, 2'b00, 16'h000f);
        // compare value zero: counter wraps once, then sticks at zero
        // reset enable dropped first so the counter is off zero when it is re-armed
        acc(1'b1, `FCTIR_IDX_SCR2, 16'h0080);
        acc(1'b1, `FCTIR_IDX_CH3, 16'h0000);
        acc(1'b1, `FCTIR_IDX_SCR2, 16'h0088);
        for (k = 0; k < 70000 && overflow_irq !== 1'b1; k++) begin
            @(posedge core_clk);
        end
        `TB_CHK(k < 70000, 1'b1)
        if (k >= 70000) begin
            stop_test();
        end
        rd(`FCTIR_IDX_FLG2, 2'b00, 16'h0080);
        rd(`FCTIR_IDX_CNT, 2'b00, 16'h0000);
        `TB_CHK(compare_match[3], 1'b1)
        acc(1'b1, `FCTIR_IDX_FLG2, 16'h0080);
        rd(`FCTIR_IDX_FLG2, 2'b00, 16'h0000);
        `TB_CHK(overflow_irq, 1'b0)
        rd(`FCTIR_IDX_CNT, 2'b00, 16'h0000);
        acc(1'b1, `FCTIR_IDX_FLG1, 16'h0003);
        rd(`FCTIR_IDX_FLG1, 2'b00, 16'h000c);
        `TB_CHK(channel_irq, 4'h4)
        // fast clear by a compare write
        acc(1'b1, `FCTIR_IDX_SCR1, 16'h0010);
        rnd = lfsr(rnd);
        acc(1'b1, `FCTIR_IDX_CH2, rnd[15:0] | 16'h0100);
        rd(`FCTIR_IDX_FLG1, 2'b00, 16'h0008);
        // capture mode: writes ignored, edge latches the counter
        acc(1'b1, `FCTIR_IDX_MODE, 16'h0008);
        acc(1'b1, `FCTIR_IDX_CH0, 16'h1234);
        rd(`FCTIR_IDX_CH0, 2'b00, v[0]);
        capture_rise_en <= 4'h2;
        @(posedge core_clk);
        capture_pin <= 4'h2;
        repeat (6) @(posedge core_clk);
        rd(`FCTIR_IDX_FLG1, 2'b00, 16'h000a);
        rd(`FCTIR_IDX_CH1, 2'b00, 16'h0000);
        rd(`FCTIR_IDX_FLG1, 2'b00, 16'h0008);
        `TB_CHK(exp_q.size(), 0)
        stop_test();
    end
endmodule

bind fctir_timer fctir_timer_monitor #(.NCH(NCH)) i_mon (.core_clk(core_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response), .channel_irq(channel_irq),
    .overflow_irq(overflow_irq), .irq(irq));
